// file: hw/err_log_pkg.sv
// package with register map, field layout and event types of the error address logger
package err_log_pkg;
  localparam logic [31:0] PORT1_SLAVE_ERROR_ADDRESS_OFS = 32'h2102_0008;
  localparam logic [31:0] PORT2_SLAVE_ERROR_ADDRESS_OFS = 32'h2102_000C;
  localparam logic [31:0] PORT1_IO_ERROR_ADDRESS_OFS = 32'h2102_0010;
  localparam logic [31:0] PORT2_IO_ERROR_ADDRESS_OFS = 32'h2102_0014;
  localparam logic [31:0] SYSTEM_BUS_ERROR_ADDRESS_OFS = 32'h2102_0018;
  localparam logic [31:0] IRQ_STATUS_OFS = 32'h2102_001C;
  localparam logic [31:0] IRQ_MASK_OFS = 32'h2102_0020;
  localparam logic [31:0] LOG_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // error summary bit positions
  localparam int P1_SLAVE_LO = 3;
  localparam int P1_SLAVE_HI = 4;
  localparam int P2_SLAVE_LO = 10;
  localparam int P2_SLAVE_HI = 11;
  localparam int SHARED_IO = 7;
  localparam int SYS_LO = 21;
  localparam int SYS_HI = 23;
  // field positions
  localparam int OCTA_LSB = 4;
  localparam int OCTA_MSB = 29;
  localparam int ID_LSB = 29;
  localparam int ADDR_MSB = 28;
  localparam int NUM_LOGS = 5;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // one failing transaction as seen by a log
  typedef struct packed {
    logic [2:0] commander;
    logic [28:0] address;
  } err_txn_type;

  // mask of summary bits owned by each log
  localparam logic [31:0] P1_SLAVE_BITS = 32'h0000_0018;
  localparam logic [31:0] P2_SLAVE_BITS = 32'h0000_0C00;
  localparam logic [31:0] P1_IO_BITS = 32'h0000_0087;
  localparam logic [31:0] P2_IO_BITS = 32'h0000_0780;
  localparam logic [31:0] SYS_BITS = 32'h00E0_0000;
endpackage : err_log_pkg

// file: hw/error_log_slot.sv
// one capture-and-hold error log slot
`timescale 1ns/1ns
`default_nettype none
module error_log_slot
  import err_log_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic anySet,
  input wire logic anyHeld,
  input wire logic [31:0] capValue,
  output logic [31:0] logValue,
  output logic captured
);
  logic holding;

  // capture on a new set while not holding, keep until all bits cleared
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      logValue <= LOG_RESET;
      holding <= 1'b0;
    end else if (anySet && !holding) begin
      logValue <= capValue;
      holding <= 1'b1;
    end else if (!anyHeld && !anySet) begin
      holding <= 1'b0;
    end
  end

  assign captured = anySet && !holding;
endmodule // error_log_slot
`default_nettype wire

// file: hw/irq_status.sv
// sticky capture status with mask and level interrupt
`timescale 1ns/1ns
`default_nettype none
module irq_status
  import err_log_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [4:0] events,
  input wire logic statusWrite,
  input wire logic maskWrite,
  input wire logic [4:0] wdata,
  output logic [4:0] status,
  output logic [4:0] mask,
  output logic irq
);
  // write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      status <= 5'h00;
    else if (statusWrite)
      status <= (status & ~wdata) | events;
    else
      status <= status | events;
  end

  // mask register
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      mask <= MASK_RESET;
    else if (maskWrite)
      mask <= wdata;
  end

  assign irq = |(status & mask);
endmodule // irq_status
`default_nettype wire

// file: hw/bus_error_address_logger.sv
// error address logger: five read-only capture logs behind a simple register port
// Summary of operation
// - port one slave error logs octaword address
// - port two slave error logs octaword address
// - slave log held until both bits clear
// - port one slave layout 29:4, zeros elsewhere
// - port two slave log same layout
// - port one I/O error logs address, id
// - port two I/O error logs address, id
// - port one I/O log held until cleared
// - port two I/O log held until cleared
// - I/O logs: id 31:29, address 28:0
// - system bus error logs address, id
// - system bus log held until cleared
// - system bus log: id 31:29, address 28:0
// - logs read-only, valid while bits set
// - all logs reset to zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module bus_error_address_logger
  import err_log_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  // error summary register set and current state
  input wire logic [31:0] summarySet,
  input wire logic [31:0] summaryState,
  // failing transaction attributes per source
  input wire logic [31:0] port1SlaveAddr,
  input wire logic [31:0] port2SlaveAddr,
  input wire err_txn_type port1IoTxn,
  input wire err_txn_type port2IoTxn,
  input wire err_txn_type sysTxn,
  // which port the shared I/O bit belongs to: 0 port one, 1 port two
  input wire logic sharedIoPort2,
  // register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] setP1Io;
  logic [31:0] setP2Io;
  logic [NUM_LOGS-1:0] anySet;
  logic [NUM_LOGS-1:0] anyHeld;
  logic [NUM_LOGS-1:0] captured;
  logic [31:0] capValue [NUM_LOGS];
  logic [31:0] logValue [NUM_LOGS];
  logic [4:0] status;
  logic [4:0] mask;
  logic statusWrite;
  logic maskWrite;

  // shared bit 7 is credited to the port that issued the failing transaction
  assign setP1Io = summarySet & (sharedIoPort2 ? (P1_IO_BITS & ~(32'h1 << SHARED_IO)) : P1_IO_BITS);
  assign setP2Io = summarySet & (sharedIoPort2 ? P2_IO_BITS : (P2_IO_BITS & ~(32'h1 << SHARED_IO)));

  // capture triggers per log
  assign anySet[0] = |(summarySet & P1_SLAVE_BITS);
  assign anySet[1] = |(summarySet & P2_SLAVE_BITS);
  assign anySet[2] = |setP1Io;
  assign anySet[3] = |setP2Io;
  assign anySet[4] = |(summarySet & SYS_BITS);

  // hold conditions: any owning bit still set
  assign anyHeld[0] = |(summaryState & P1_SLAVE_BITS);
  assign anyHeld[1] = |(summaryState & P2_SLAVE_BITS);
  assign anyHeld[2] = |(summaryState & P1_IO_BITS);
  assign anyHeld[3] = |(summaryState & P2_IO_BITS);
  assign anyHeld[4] = |(summaryState & SYS_BITS);

  // captured words in register layout
  assign capValue[0] = {2'b00, port1SlaveAddr[OCTA_MSB:OCTA_LSB], 4'h0};
  assign capValue[1] = {2'b00, port2SlaveAddr[OCTA_MSB:OCTA_LSB], 4'h0};
  assign capValue[2] = port1IoTxn;
  assign capValue[3] = port2IoTxn;
  assign capValue[4] = sysTxn;

  ////////////////////////////////////////////////////////////////////////
  // one slot per log; only hardware capture updates it
  genvar g;
  generate
    for (g = 0; g < NUM_LOGS; g++) begin : g_slot
      error_log_slot u_slot (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .anySet(anySet[g]),
        .anyHeld(anyHeld[g]),
        .capValue(capValue[g]),
        .logValue(logValue[g]),
        .captured(captured[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  assign statusWrite = regWrite && (regAddr == IRQ_STATUS_OFS);
  assign maskWrite = regWrite && (regAddr == IRQ_MASK_OFS);

  // capture events raise sticky interrupt status
  irq_status u_irq (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .events(captured),
    .statusWrite(statusWrite),
    .maskWrite(maskWrite),
    .wdata(regWdata[4:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; writes to logs are ignored
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      regRdata <= UNMAPPED_READ;
    end else if (regRead) begin
      case (regAddr)
        PORT1_SLAVE_ERROR_ADDRESS_OFS: regRdata <= logValue[0];
        PORT2_SLAVE_ERROR_ADDRESS_OFS: regRdata <= logValue[1];
        PORT1_IO_ERROR_ADDRESS_OFS: regRdata <= logValue[2];
        PORT2_IO_ERROR_ADDRESS_OFS: regRdata <= logValue[3];
        SYSTEM_BUS_ERROR_ADDRESS_OFS: regRdata <= logValue[4];
        IRQ_STATUS_OFS: regRdata <= {27'h0, status};
        IRQ_MASK_OFS: regRdata <= {27'h0, mask};
        default: regRdata <= UNMAPPED_READ;
      endcase
    end else begin
      regRdata <= UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_p1_slave_capture;
    @(posedge sys_clk) disable iff (!nrst)
    captured[0] |=> logValue[0] == {2'b00, $past(port1SlaveAddr[OCTA_MSB:OCTA_LSB]), 4'h0};
  endproperty
  a_p1_slave_capture: assert property (p_p1_slave_capture) else $error("port1 slave log wrong");

  property p_p2_slave_capture;
    @(posedge sys_clk) disable iff (!nrst)
    captured[1] |=> logValue[1] == {2'b00, $past(port2SlaveAddr[OCTA_MSB:OCTA_LSB]), 4'h0};
  endproperty
  a_p2_slave_capture: assert property (p_p2_slave_capture) else $error("port2 slave log wrong");

  property p_slave_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (anyHeld[0] && !captured[0]) |=> $stable(logValue[0]);
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave log changed while held");

  property p_slave_zero_bits;
    @(posedge sys_clk) disable iff (!nrst)
    logValue[0][31:30] == 2'b00 && logValue[0][3:0] == 4'h0 &&
      logValue[1][31:30] == 2'b00 && logValue[1][3:0] == 4'h0;
  endproperty
  a_slave_zero_bits: assert property (p_slave_zero_bits) else $error("slave log zero bits set");

  property p_p1_io_capture;
    @(posedge sys_clk) disable iff (!nrst)
    captured[2] |=> logValue[2] == $past(port1IoTxn);
  endproperty
  a_p1_io_capture: assert property (p_p1_io_capture) else $error("port1 io log wrong");

  property p_p2_io_capture;
    @(posedge sys_clk) disable iff (!nrst)
    captured[3] |=> logValue[3] == $past(port2IoTxn);
  endproperty
  a_p2_io_capture: assert property (p_p2_io_capture) else $error("port2 io log wrong");

  property p_sys_capture;
    @(posedge sys_clk) disable iff (!nrst)
    captured[4] |=> logValue[4] == $past(sysTxn);
  endproperty
  a_sys_capture: assert property (p_sys_capture) else $error("system log wrong");

  property p_no_overwrite;
    @(posedge sys_clk) disable iff (!nrst)
    (anySet[2] && anyHeld[2] && !captured[2]) |=> $stable(logValue[2]);
  endproperty
  a_no_overwrite: assert property (p_no_overwrite) else $error("io log overwritten");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!nrst)
    captured[4] && mask[4] && !maskWrite |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt missing after capture");

  // port two slave log keeps its zero fields
  property p_p2_slave_zero_bits;
    @(posedge sys_clk) disable iff (!nrst)
    captured[1] |=> logValue[1][31:30] == 2'b00 && logValue[1][3:0] == 4'h0;
  endproperty
  a_p2_slave_zero_bits: assert property (p_p2_slave_zero_bits) else $error("p2 zero bits");

  // port two slave log frozen while held
  property p_p2_slave_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (anyHeld[1] && !captured[1]) |=> $stable(logValue[1]);
  endproperty
  a_p2_slave_hold: assert property (p_p2_slave_hold) else $error("p2 slave log changed");

  // port one io log frozen while held
  property p_p1_io_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (anyHeld[2] && !captured[2]) |=> $stable(logValue[2]);
  endproperty
  a_p1_io_hold: assert property (p_p1_io_hold) else $error("p1 io log changed while held");

  // port two io log frozen while held
  property p_p2_io_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (anyHeld[3] && !captured[3]) |=> $stable(logValue[3]);
  endproperty
  a_p2_io_hold: assert property (p_p2_io_hold) else $error("p2 io log changed while held");

  // system bus log frozen while held
  property p_sys_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (anyHeld[4] && !captured[4]) |=> $stable(logValue[4]);
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("system log changed while held");

  // io log layout: commander on top, address below
  property p_io_layout;
    @(posedge sys_clk) disable iff (!nrst)
    captured[3] |=> logValue[3][31:29] == $past(port2IoTxn.commander) &&
      logValue[3][28:0] == $past(port2IoTxn.address);
  endproperty
  a_io_layout: assert property (p_io_layout) else $error("io log layout wrong");

  // system bus log layout
  property p_sys_layout;
    @(posedge sys_clk) disable iff (!nrst)
    captured[4] |=> logValue[4][28:0] == $past(sysTxn.address);
  endproperty
  a_sys_layout: assert property (p_sys_layout) else $error("system log address wrong");

  // reset clears every log
  property p_reset_logs;
    @(posedge sys_clk)
    !nrst |=> logValue[0] == LOG_RESET && logValue[1] == LOG_RESET &&
      logValue[2] == LOG_RESET && logValue[3] == LOG_RESET && logValue[4] == LOG_RESET;
  endproperty
  a_reset_logs: assert property (p_reset_logs) else $error("log not cleared by reset");

  // read data only in the cycle after a read strobe
  property p_read_idle;
    @(posedge sys_clk) disable iff (!nrst)
    !regRead |=> regRdata == UNMAPPED_READ;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");

  // a log read returns the held word
  property p_read_log;
    @(posedge sys_clk) disable iff (!nrst)
    (regRead && regAddr == PORT1_SLAVE_ERROR_ADDRESS_OFS) |=> regRdata == $past(logValue[0]);
  endproperty
  a_read_log: assert property (p_read_log) else $error("log read data wrong");

  // logs change only on a capture, never by a write
  property p_only_capture;
    @(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> ($past(captured[0]) || $stable(logValue[0])) &&
      ($past(captured[1]) || $stable(logValue[1])) &&
      ($past(captured[2]) || $stable(logValue[2])) &&
      ($past(captured[3]) || $stable(logValue[3])) &&
      ($past(captured[4]) || $stable(logValue[4]));
  endproperty
  a_only_capture: assert property (p_only_capture) else $error("log changed without capture");

  // later slave error while held does not overwrite
  property p_slave_no_overwrite;
    @(posedge sys_clk) disable iff (!nrst)
    (anySet[0] && anyHeld[0] && !captured[0]) |=> $stable(logValue[0]);
  endproperty
  a_slave_no_overwrite: assert property (p_slave_no_overwrite) else $error("slave log overwritten");

  // later port two io error while held does not overwrite
  property p_p2_io_no_overwrite;
    @(posedge sys_clk) disable iff (!nrst)
    (anySet[3] && anyHeld[3] && !captured[3]) |=> $stable(logValue[3]);
  endproperty
  a_p2_io_no_overwrite: assert property (p_p2_io_no_overwrite) else $error("p2 io log overwritten");

  // later system error while held does not overwrite
  property p_sys_no_overwrite;
    @(posedge sys_clk) disable iff (!nrst)
    (anySet[4] && anyHeld[4] && !captured[4]) |=> $stable(logValue[4]);
  endproperty
  a_sys_no_overwrite: assert property (p_sys_no_overwrite) else $error("system log overwritten");

  // every capture raises its status bit
  property p_capture_status;
    @(posedge sys_clk) disable iff (!nrst)
    (|captured) |=> (status & $past(captured)) == $past(captured);
  endproperty
  a_capture_status: assert property (p_capture_status) else $error("capture lost in status");

  // status bit stays until written
  property p_status_sticky;
    @(posedge sys_clk) disable iff (!nrst)
    (status[0] && !statusWrite) |=> status[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit dropped");

  // write one clears a status bit when no new capture
  property p_status_clear;
    @(posedge sys_clk) disable iff (!nrst)
    (statusWrite && regWdata[0] && !captured[0]) |=> !status[0];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");

  // mask register takes the written value
  property p_mask_write;
    @(posedge sys_clk) disable iff (!nrst)
    maskWrite |=> mask == $past(regWdata[4:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  // fully masked means no interrupt
  property p_irq_masked;
    @(posedge sys_clk) disable iff (!nrst)
    (mask == 5'h00) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while fully masked");

  c_p1_slave: cover property (@(posedge sys_clk) disable iff (!nrst) captured[0]);
  c_overlap: cover property (@(posedge sys_clk) disable iff (!nrst) captured[1] && captured[3]);
  c_sys: cover property (@(posedge sys_clk) disable iff (!nrst) captured[4]);
  c_held_set: cover property (@(posedge sys_clk) disable iff (!nrst) anySet[3] && !captured[3]);
  c_read_log: cover property (@(posedge sys_clk) disable iff (!nrst)
    regRead && regAddr == PORT1_IO_ERROR_ADDRESS_OFS);
endmodule // bus_error_address_logger
`default_nettype wire

// file: sim/bus_error_address_logger_tb.sv
// self-checking testbench of the error address logger
`timescale 1ns/1ns
`default_nettype none
module bus_error_address_logger_tb
  import err_log_pkg::*;
();
  logic sys_clk;
  logic nrst;
  logic [31:0] summarySet, summaryState, port1SlaveAddr, port2SlaveAddr;
  err_txn_type port1IoTxn, port2IoTxn, sysTxn;
  logic sharedIoPort2, regWrite, regRead, irq;
  logic [31:0] regAddr, regWdata, regRdata, d, d2, v;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] ofs [5] = '{PORT1_SLAVE_ERROR_ADDRESS_OFS, PORT2_SLAVE_ERROR_ADDRESS_OFS,
    PORT1_IO_ERROR_ADDRESS_OFS, PORT2_IO_ERROR_ADDRESS_OFS, SYSTEM_BUS_ERROR_ADDRESS_OFS};
  // summary bits that trigger each log, every one used for capture at least once
  int bits [5][4] = '{'{3, 4, 3, 4}, '{10, 11, 10, 11}, '{7, 0, 1, 2}, '{7, 8, 9, 10},
    '{21, 22, 23, 21}};

  bus_error_address_logger dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .summarySet(summarySet), .summaryState(summaryState),
    .port1SlaveAddr(port1SlaveAddr), .port2SlaveAddr(port2SlaveAddr),
    .port1IoTxn(port1IoTxn), .port2IoTxn(port2IoTxn), .sysTxn(sysTxn),
    .sharedIoPort2(sharedIoPort2), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // compare, bus and event tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= wd;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    check(name, regRdata, exp);
  endtask

  // one-cycle set pulse; sources show inverted data once the pulse is gone
  task automatic fire(input int i, input int b, input logic [31:0] fd);
    @(posedge sys_clk);
    summarySet <= 32'h1 << b;
    summaryState <= summaryState | (32'h1 << b);
    sharedIoPort2 <= (i == 3);
    {port1SlaveAddr, port2SlaveAddr, port1IoTxn, port2IoTxn, sysTxn} <= {5{fd}};
    @(posedge sys_clk);
    summarySet <= 32'h0;
    {port1SlaveAddr, port2SlaveAddr, port1IoTxn, port2IoTxn, sysTxn} <= {5{~fd}};
  endtask

  function automatic logic [31:0] exp_log(input int i, input logic [31:0] ed);
    return (i < 2) ? {2'h0, ed[29:4], 4'h0} : ed;
  endfunction

  // logs that two summary bits trigger; bit 10 is shared by a slave and an io log
  function automatic logic [31:0] exp_status(input int i, input int b1, input int b2);
    logic [31:0] s;
    logic [31:0] m [5];
    s = 32'h0;
    m = '{P1_SLAVE_BITS, P2_SLAVE_BITS, P1_IO_BITS, P2_IO_BITS, SYS_BITS};
    if (i == 3) m[2][SHARED_IO] = 1'b0;
    else m[3][SHARED_IO] = 1'b0;
    for (int k = 0; k < 5; k++) s[k] = m[k][b1] | m[k][b2];
    return s;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {summarySet, summaryState, port1SlaveAddr, port2SlaveAddr} = '0;
    {port1IoTxn, port2IoTxn, sysTxn, regAddr, regWdata} = '0;
    {sharedIoPort2, regWrite, regRead} = '0;
    nrst = 1'b0;
    void'($urandom(32'hB9711576));
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rdchk("log reset", ofs[i], LOG_RESET);
    rdchk("status reset", IRQ_STATUS_OFS, 32'h0);
    rdchk("mask reset", IRQ_MASK_OFS, 32'h0);
    rdchk("unmapped", 32'h2102_0024, UNMAPPED_READ);
    $display("test reset done");
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 5; i++) begin
        d = $urandom;
        d2 = $urandom;
        fire(i, bits[i][j], d);
        rdchk("log capture", ofs[i], exp_log(i, d));
        fire(i, bits[i][(j + 1) % 4], d2);
        wr(ofs[i], d2);
        rdchk("log held", ofs[i], exp_log(i, d));
        rdchk("status", IRQ_STATUS_OFS, exp_status(i, bits[i][j], bits[i][(j + 1) % 4]));
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(IRQ_MASK_OFS, 32'h1 << i);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(IRQ_STATUS_OFS, 32'h1F);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(IRQ_MASK_OFS, 32'h0);
        @(posedge sys_clk);
        summaryState <= 32'h0;
      end
      $display("test capture round %0d done", j);
    end
    tally_and_finish();
  end
endmodule // bus_error_address_logger_tb
`default_nettype wire
